// *** hw/flash_seq.sv ***
`timescale 1ns/10ps
// Function
// (RULE1) Dummy count 2,4,6,8,10 from select field
// (RULE2) Dummy count already includes two mode clocks
// (RULE3) Host limits clock per read setting
// (RULE4) Quad read honours align bit; aligned read ignores
// (RULE5) Host uses lower clocks in wrap mode
// (RULE6) Decode three erase opcodes, three block sizes
// (RULE7) Erase needs write latch set by enable
// (RULE8) Host sends opcode, 24 address bits, serially
// (RULE9) Erase starts only at chip select release
// (RULE10) Ignore low address bits per block size
// (RULE11) Busy bit set while erase runs
// (RULE12) Clear write latch before erase finishes
// (RULE13) Host polls status instead of waiting
// (RULE14) Partial byte at release aborts, clears latch
// (RULE15) Short address aborts erase, clears latch
// (RULE16) Protected block: no erase, clear latch
// (RULE17) Aligned read forces low address bits zero
// (RULE18) Mode field decides continuous read entry
// (RULE19) After dummies drive four lines, high nibble first
// (RULE20) Dummy select above four is undefined
module flash_seq
#(
    parameter int MEM_ADDR_BITS = 19,
    parameter int BLOCK_ERASE_US = 50000
)
(
    input wire logic clk,
    input wire logic reset,
    input wire logic sck,
    input wire logic cs_n,
    input wire logic [3:0] io_in,
    output logic [3:0] io_out,
    output logic [3:0] io_oe,
    input wire logic dword_align_sel,
    input wire logic [2:0] dummy_cycle_sel,
    input wire logic wrap_mode,
    input wire logic block_protected,
    input wire logic [7:0] read_data,
    output logic [MEM_ADDR_BITS-1:0] read_addr,
    output logic [23:0] erase_addr,
    output flash_seq_pkg::erase_size_t erase_size,
    output logic erase_start,
    output logic write_latch_en,
    output logic op_in_progress,
    output logic continuous_read,
    output logic [7:0] first_status_reg
);
    import flash_seq_pkg::*;
    localparam int ERASE_CYCLES = BLOCK_ERASE_US * CLK_MHZ; // Erase length
    // ------------------------------------------------------------
    // Helper functions
    // ------------------------------------------------------------
    // Dummy clocks from the select field; undefined codes clamp to 10
    function automatic logic [4:0] dummy_clocks(input logic [2:0] sel);
        logic [2:0] s;
        s = (sel > DUMMY_SEL_MAX) ? DUMMY_SEL_MAX : sel; // RULE20
        return DUMMY_BASE + {1'b0, s, 1'b0}; // RULE1
    endfunction
    // True for any of the three erase opcodes
    function automatic logic is_erase(input logic [7:0] op);
        return (op == OP_ERASE_4K) || (op == OP_ERASE_32K) ||
            (op == OP_ERASE_64K);
    endfunction
    // Clear the bits that the block size makes irrelevant
    function automatic logic [23:0] block_base(input logic [23:0] a,
        input erase_size_t sz);
        return a & ~((sz == ERASE_4K) ? MASK_4K :
            (sz == ERASE_32K) ? MASK_32K : MASK_64K); // RULE10
    endfunction

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic sck_s1, sck_s2, sck_s3; // Link clock, third stage for edges
    logic cs_s1, cs_s2, cs_s3; // Chip select, third stage for edges
    logic [3:0] io_s1, io_s2; // Data lines, one stage fewer than the clock
    // Two flops per data pin, three on clock and select; the link is far slower than clk
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            {sck_s1, sck_s2, sck_s3} <= 3'h0;
            {cs_s1, cs_s2, cs_s3} <= 3'h7;
            {io_s1, io_s2} <= 8'h00;
        end
        else
        begin
            {sck_s3, sck_s2, sck_s1} <= {sck_s2, sck_s1, sck};
            {cs_s3, cs_s2, cs_s1} <= {cs_s2, cs_s1, cs_n};
            {io_s2, io_s1} <= {io_s1, io_in};
        end
    end

    logic sck_rise; // Sampling edge (modes 0 and 3)
    logic sck_fall; // Launch edge for read data
    logic cs_rise; // Frame end
    assign sck_rise = sck_s2 & ~sck_s3 & ~cs_s2;
    assign sck_fall = ~sck_s2 & sck_s3 & ~cs_s2;
    assign cs_rise = cs_s2 & ~cs_s3;

    // ------------------------------------------------------------
    // Frame decoder
    // ------------------------------------------------------------
    state_t state; // Decoder state
    logic [4:0] cnt; // Clocks within the current phase
    logic [7:0] shift; // Command shifter
    logic [7:0] cmd; // Latched opcode
    logic cmd_valid; // A whole opcode arrived this frame
    logic addr_full; // All three address bytes arrived
    logic [23:0] addr; // Address shifter
    logic [7:0] mode_field; // Continuous read mode bits
    logic [2:0] bit_phase; // Clocks modulo eight since select
    logic dummy_last; // Final dummy clock sampled now
    logic [7:0] next_mode; // Mode field including this nibble
    assign dummy_last = (state == ST_DUMMY) && sck_rise &&
        (cnt == dummy_clocks(dummy_cycle_sel) - 5'h01); // RULE2
    assign next_mode = {mode_field[3:0], io_s2};

    // Clocks modulo eight decide whether the frame ended on a byte
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
            bit_phase <= BYTE_PHASE_ZERO;
        else if (state == ST_IDLE)
            bit_phase <= BYTE_PHASE_ZERO;
        else if (sck_rise)
            bit_phase <= bit_phase + 3'h1;
    end

    // Main sequence: command, address, dummies, data
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            state <= ST_IDLE;
            {cnt, cmd_valid, addr_full} <= 7'h00;
            {shift, cmd, mode_field} <= 24'h000000;
            addr <= 24'h000000;
        end
        else if (cs_s2)
            state <= ST_IDLE; // Select released: every frame ends here
        else
        begin
            case (state)
                ST_IDLE:
                begin
                    {cnt, cmd_valid, addr_full} <= 7'h00;
                    // Continuous read skips the opcode entirely
                    state <= continuous_read ? ST_ADDR_QUAD : ST_CMD; // RULE18
                end
                ST_CMD:
                if (sck_rise)
                begin
                    shift <= {shift[6:0], io_s2[0]};
                    cnt <= cnt + 5'h01;
                    if (cnt == CMD_CLOCKS - 5'h01)
                    begin
                        cmd <= {shift[6:0], io_s2[0]};
                        cmd_valid <= 1'b1;
                        cnt <= 5'h00;
                        // Nothing but status is served while busy
                        if (op_in_progress)
                            state <= ST_IGNORE;
                        else if (is_erase({shift[6:0], io_s2[0]}))
                            state <= ST_ADDR_SERIAL; // RULE6
                        else if ({shift[6:0], io_s2[0]} == OP_READ_QUAD ||
                            {shift[6:0], io_s2[0]} == OP_READ_QUAD_ALIGNED)
                            state <= ST_ADDR_QUAD;
                        else
                            state <= ST_IGNORE;
                    end
                end
                ST_ADDR_SERIAL:
                if (sck_rise)
                begin
                    addr <= {addr[22:0], io_s2[0]};
                    cnt <= cnt + 5'h01;
                    if (cnt == ADDR_CLOCKS_SERIAL - 5'h01)
                    begin
                        addr_full <= 1'b1; // RULE15
                        state <= ST_IGNORE;
                    end
                end
                ST_ADDR_QUAD:
                if (sck_rise)
                begin
                    addr <= {addr[19:0], io_s2};
                    cnt <= cnt + 5'h01;
                    if (cnt == ADDR_CLOCKS_QUAD - 5'h01)
                    begin
                        cnt <= 5'h00;
                        state <= ST_DUMMY;
                    end
                end
                ST_DUMMY:
                if (sck_rise)
                begin
                    // The first two dummy clocks carry the mode field
                    if (cnt < MODE_CLOCKS)
                        mode_field <= next_mode; // RULE2
                    cnt <= cnt + 5'h01;
                    if (dummy_last)
                        state <= ST_DATA;
                end
                ST_DATA, ST_IGNORE:
                    state <= state;
                default:
                    state <= ST_IDLE;
            endcase
        end
    end
    // Continuous read is decided as the second mode nibble arrives, so
    // even two dummy clocks update it; the setting then holds
    // across frames until a later mode field drops it
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
            continuous_read <= 1'b0;
        else if (state == ST_DUMMY && sck_rise &&
            cnt == MODE_CLOCKS - 5'h01)
            continuous_read <= (next_mode[MODE_CONT_HI:MODE_CONT_LO] ==
                MODE_CONT_PATTERN); // RULE18
    end

    // ------------------------------------------------------------
    // Read data path
    // ------------------------------------------------------------
    logic nib_lo; // Next nibble to launch is the low one
    logic [23:0] start_addr; // Read start after alignment
    // Aligned opcode always, the other one only with the align bit
    assign start_addr = (cmd == OP_READ_QUAD_ALIGNED || dword_align_sel) ?
        (addr & ~MASK_DWORD) : addr; // RULE4 RULE17

    // Drive on the falling edge so data is stable at the host's rise
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            read_addr <= '0;
            nib_lo <= 1'b0;
            {io_out, io_oe} <= 8'h00;
        end
        else if (dummy_last)
        begin
            read_addr <= start_addr[MEM_ADDR_BITS-1:0];
            nib_lo <= 1'b0;
        end
        else if (state != ST_DATA)
        begin
            // Lines float whenever no read data is owed
            io_oe <= 4'h0;
            nib_lo <= 1'b0;
        end
        else if (sck_fall)
        begin
            io_oe <= 4'hf; // RULE19
            if (!nib_lo)
                io_out <= read_data[7:4]; // RULE19
            else
            begin
                io_out <= read_data[3:0];
                // Past the top of the array the count simply wraps
                read_addr <= read_addr + 1'b1;
            end
            nib_lo <= ~nib_lo;
        end
    end
    // Erase size follows the opcode; the base is published for protection
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            erase_size <= ERASE_4K;
            erase_addr <= 24'h000000;
        end
        else
        begin
            case (cmd)
                OP_ERASE_4K: erase_size <= ERASE_4K; // RULE6
                OP_ERASE_32K: erase_size <= ERASE_32K; // RULE6
                default: erase_size <= ERASE_64K; // RULE6
            endcase
            erase_addr <= block_base(addr, erase_size); // RULE10
        end
    end

    // ------------------------------------------------------------
    // Frame end evaluation
    // ------------------------------------------------------------
    logic erase_seen; // Frame carried an erase opcode
    logic erase_ok; // Erase may start at this release
    logic wren_seen; // Frame carried write enable
    assign erase_seen = cs_rise && cmd_valid && is_erase(cmd) &&
        !op_in_progress && write_latch_en; // RULE7
    assign erase_ok = erase_seen && (bit_phase == BYTE_PHASE_ZERO) &&
        addr_full && !block_protected; // RULE14 RULE15 RULE16
    assign wren_seen = cs_rise && cmd_valid && cmd == OP_WRITE_ENABLE &&
        !op_in_progress && (bit_phase == BYTE_PHASE_ZERO);

    // Write latch: any erase attempt, good or bad, leaves it clear
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
            write_latch_en <= 1'b0;
        else if (wren_seen)
            write_latch_en <= 1'b1; // RULE7
        else if (erase_seen)
            write_latch_en <= 1'b0; // RULE12 RULE14 RULE15 RULE16
    end

    // ------------------------------------------------------------
    // Self-timed erase
    // ------------------------------------------------------------
    logic [31:0] erase_timer; // Cycles left of the erase
    // Starts only on release; a held select never triggers it
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            {erase_start, op_in_progress} <= 2'b00;
            erase_timer <= 32'h0;
        end
        else
        begin
            erase_start <= erase_ok; // RULE9
            if (erase_ok)
            begin
                op_in_progress <= 1'b1; // RULE11
                erase_timer <= 32'(ERASE_CYCLES);
            end
            else if (op_in_progress)
            begin
                erase_timer <= erase_timer - 32'h1;
                if (erase_timer == 32'h1)
                    op_in_progress <= 1'b0; // RULE11
            end
        end
    end
    // Status view: only busy and latch live here, other bits elsewhere
    assign first_status_reg = (8'(op_in_progress) << SR_BUSY_BIT) |
        (8'(write_latch_en) << SR_WEL_BIT); // RULE11

endmodule // flash_seq

// *** hw/flash_seq_pkg.sv ***
package flash_seq_pkg;

    // ------------------------------------------------------------
    // Command opcodes
    // ------------------------------------------------------------
    localparam logic [7:0] OP_ERASE_4K = 8'h20;
    localparam logic [7:0] OP_ERASE_32K = 8'h52;
    localparam logic [7:0] OP_ERASE_64K = 8'hd8;
    localparam logic [7:0] OP_READ_QUAD = 8'heb;
    localparam logic [7:0] OP_READ_QUAD_ALIGNED = 8'he7;
    localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;

    // ------------------------------------------------------------
    // Frame layout, counted in serial clocks
    // ------------------------------------------------------------
    localparam logic [4:0] CMD_CLOCKS = 5'h08;
    localparam logic [4:0] ADDR_CLOCKS_SERIAL = 5'h18;
    localparam logic [4:0] ADDR_CLOCKS_QUAD = 5'h06;
    localparam logic [4:0] MODE_CLOCKS = 5'h02;
    localparam logic [4:0] DUMMY_BASE = 5'h02;
    localparam logic [2:0] DUMMY_SEL_MAX = 3'h4;
    localparam logic [2:0] BYTE_PHASE_ZERO = 3'h0;

    // Mode field: these two bits set to this pattern keep continuous read
    localparam logic [1:0] MODE_CONT_PATTERN = 2'h2;
    localparam int MODE_CONT_HI = 5;
    localparam int MODE_CONT_LO = 4;

    // ------------------------------------------------------------
    // Address masks of the three erase sizes and of dword alignment (ignored low bits)
    // ------------------------------------------------------------
    localparam logic [23:0] MASK_4K = 24'h000fff;
    localparam logic [23:0] MASK_32K = 24'h007fff;
    localparam logic [23:0] MASK_64K = 24'h00ffff;
    localparam logic [23:0] MASK_DWORD = 24'h000003;

    // ------------------------------------------------------------
    // First status register bit positions
    // ------------------------------------------------------------
    localparam int SR_BUSY_BIT = 0;
    localparam int SR_WEL_BIT = 1;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_MHZ = 125;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        ERASE_4K = 2'b00,
        ERASE_32K = 2'b01,
        ERASE_64K = 2'b10
    } erase_size_t;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_CMD = 3'b001,
        ST_ADDR_SERIAL = 3'b010,
        ST_ADDR_QUAD = 3'b011,
        ST_DUMMY = 3'b100,
        ST_DATA = 3'b101,
        ST_IGNORE = 3'b110
    } state_t;

endpackage

// *** bench/flash_seq_assertions.sv ***
`timescale 1ns/10ps
// ------------------------------------------------------------
// Port checks for erase launch, status and line release
// ------------------------------------------------------------
module flash_seq_assertions
(
    input wire logic clk,
    input wire logic reset,
    input wire logic cs_n,
    input wire logic [3:0] io_oe,
    input wire logic block_protected,
    input wire logic [23:0] erase_addr,
    input wire flash_seq_pkg::erase_size_t erase_size,
    input wire logic erase_start,
    input wire logic write_latch_en,
    input wire logic op_in_progress,
    input wire logic [7:0] first_status_reg
);
    import flash_seq_pkg::*;

    // Ignored low address bits of the current block size
    logic [23:0] msk;

    // Mask follows the size output so both are judged together
    always_comb
    begin
        if (erase_size == ERASE_4K)
            msk = MASK_4K;
        else if (erase_size == ERASE_32K)
            msk = MASK_32K;
        else
            msk = MASK_64K;
    end

    default clocking @(posedge clk); endclocking
    default disable iff (reset);

    property p_start_latch;
        erase_start |-> $past(write_latch_en);
    endproperty
    a_start_latch: assert property (p_start_latch)
        else $error("erase began without the write latch");

    property p_start_state;
        erase_start |-> op_in_progress && !write_latch_en;
    endproperty
    a_start_state: assert property (p_start_state)
        else $error("busy or latch wrong at erase launch");

    property p_start_cs;
        erase_start |-> cs_n && $past(cs_n, 3);
    endproperty
    a_start_cs: assert property (p_start_cs)
        else $error("erase launched while selected");

    property p_pulse;
        erase_start |=> !erase_start;
    endproperty
    a_pulse: assert property (p_pulse)
        else $error("erase launch longer than one clock");

    property p_mask;
        erase_start |-> (erase_addr & msk) == 24'h000000;
    endproperty
    a_mask: assert property (p_mask)
        else $error("erase base keeps ignored bits");

    property p_protect;
        erase_start |-> !$past(block_protected);
    endproperty
    a_protect: assert property (p_protect)
        else $error("protected block erased");

    property p_status;
        first_status_reg == {6'h00, write_latch_en, op_in_progress};
    endproperty
    a_status: assert property (p_status)
        else $error("status byte does not show busy and latch");

    property p_busy_latch;
        op_in_progress |-> !$rose(write_latch_en);
    endproperty
    a_busy_latch: assert property (p_busy_latch)
        else $error("write latch set while busy");

    property p_oe_idle;
        cs_n [*8] |-> io_oe == 4'h0;
    endproperty
    a_oe_idle: assert property (p_oe_idle)
        else $error("data lines driven while deselected");

    c_erase: cover property (erase_start);
    c_read: cover property (io_oe == 4'hf);
    c_abort: cover property ($fell(write_latch_en) && !erase_start);
endmodule // flash_seq_assertions

bind flash_seq flash_seq_assertions u_chk (.clk(clk), .reset(reset),
    .cs_n(cs_n), .io_oe(io_oe), .block_protected(block_protected),
    .erase_addr(erase_addr), .erase_size(erase_size),
    .erase_start(erase_start), .write_latch_en(write_latch_en),
    .op_in_progress(op_in_progress), .first_status_reg(first_status_reg));

// *** bench/flash_host_model.sv ***
`timescale 1ns/10ps
// ------------------------------------------------------------
// Host controller: link clock, select and data lines
// ------------------------------------------------------------
module flash_host_model
(
    input wire logic clk,
    output logic sck,
    output logic cs_n,
    output logic [3:0] io_in
);
    // Link clock stands low outside frames
    initial
    begin
        sck = 1'b0;
        cs_n = 1'b1;
        io_in = 4'h0;
    end

    // 40 ns half period, under every read speed limit, wrap or not
    task automatic half();
        repeat (5) @(negedge clk);
    endtask

    // One link clock carrying a nibble
    task automatic pulse(input logic [3:0] v);
        io_in = v;
        half();
        sck = 1'b1;
        half();
        sck = 1'b0;
    endtask

    task automatic open_frame();
        cs_n = 1'b0;
        half();
    endtask

    // Released lines flip so stale data is never mistaken for valid
    task automatic close_frame();
        half();
        cs_n = 1'b1;
        io_in = ~io_in;
    endtask

    // Serial bits on line 0, most significant first
    task automatic send_bits(input logic [39:0] d, input int n);
        for (int i = 39; i > 39 - n; i--)
            pulse({~d[i], 2'h1, d[i]});
    endtask
endmodule // flash_host_model

// *** bench/test_flash_quad_dummy_and_block_erase.sv ***
`timescale 1ns/10ps
// ------------------------------------------------------------
// Bench for the erase and quad read sequencer
// ------------------------------------------------------------
module test_flash_quad_dummy_and_block_erase;
    import flash_seq_pkg::*;

    localparam int ADDR_BITS = 19;
    localparam int ERASE_CYCLES = 125; // One microsecond of erase
    logic clk = 1'b0;
    logic reset = 1'b1;
    wire logic sck;
    wire logic cs_n;
    wire logic [3:0] io_in;
    logic [3:0] io_out;
    logic [3:0] io_oe;
    logic dword_align_sel = 1'b0;
    logic [2:0] dummy_cycle_sel = 3'h0;
    logic wrap_mode = 1'b0;
    logic block_protected = 1'b0;
    logic [7:0] read_data;
    logic [ADDR_BITS-1:0] read_addr;
    logic [23:0] erase_addr;
    erase_size_t erase_size;
    logic erase_start;
    logic write_latch_en;
    logic op_in_progress;
    logic continuous_read;
    logic [7:0] first_status_reg;
    int n_errors = 0;
    int n_tests = 0;
    logic [31:0] seed = 32'h1e8685ac;

    always #4 clk = ~clk;

    // Memory contents seen by the read path
    function automatic logic [7:0] mem_byte(input logic [ADDR_BITS-1:0] a);
        return a[7:0] ^ a[15:8] ^ 8'h5a;
    endfunction
    assign read_data = mem_byte(read_addr);

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    flash_host_model host (.clk(clk), .sck(sck), .cs_n(cs_n), .io_in(io_in));

    flash_seq #(.MEM_ADDR_BITS(ADDR_BITS), .BLOCK_ERASE_US(1)) i_dut (
        .clk(clk), .reset(reset), .sck(sck), .cs_n(cs_n), .io_in(io_in),
        .io_out(io_out), .io_oe(io_oe), .dword_align_sel(dword_align_sel),
        .dummy_cycle_sel(dummy_cycle_sel), .wrap_mode(wrap_mode),
        .block_protected(block_protected), .read_data(read_data),
        .read_addr(read_addr), .erase_addr(erase_addr),
        .erase_size(erase_size), .erase_start(erase_start),
        .write_latch_en(write_latch_en), .op_in_progress(op_in_progress),
        .continuous_read(continuous_read),
        .first_status_reg(first_status_reg));

    // ------------------------------------------------------------
    // Reporting
    // ------------------------------------------------------------
    task automatic check(input logic ok, input string msg);
        n_tests++;
        if (ok !== 1'b1)
        begin
            n_errors++;
            $display("BAD %0t %s", $time, msg);
        end
    endtask

    task automatic wrap_up();
        $display("tests %0d mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task automatic write_enable();
        host.open_frame();
        host.send_bits({OP_WRITE_ENABLE, 32'h0}, 8);
        host.close_frame();
        repeat (6) @(negedge clk);
    endtask

    // ------------------------------------------------------------
    // Erase frame of n bits, with or without enable and protection
    // ------------------------------------------------------------
    task automatic erase_case(input logic [7:0] op, input logic we,
                              input int n, input logic prot);
        logic [23:0] a;
        logic [23:0] m;
        erase_size_t sz;
        logic seen;
        time t0;
        a = 24'(rnd());
        m = (op == OP_ERASE_4K) ? MASK_4K :
            (op == OP_ERASE_32K) ? MASK_32K : MASK_64K;
        sz = (op == OP_ERASE_4K) ? ERASE_4K :
             (op == OP_ERASE_32K) ? ERASE_32K : ERASE_64K;
        seen = 1'b0;
        t0 = 0;
        wrap_mode = seed[3];
        block_protected = prot;
        if (we)
            write_enable();
        check(write_latch_en === we, "latch after enable");
        host.open_frame();
        host.send_bits({op, a, 8'h00}, n);
        host.close_frame();
        for (int i = 0; i < 12; i++)
        begin
            @(negedge clk);
            if (erase_start === 1'b1)
            begin
                seen = 1'b1;
                t0 = $time;
                check(erase_addr === (a & ~m), "block base");
                check(erase_size === sz, "block size");
                check(op_in_progress === 1'b1, "busy at launch");
            end
        end
        check(seen === (we && n == 32 && !prot), "launch");
        check(write_latch_en === 1'b0, "latch left set");
        // Enable sent while busy must be ignored
        if (seen)
        begin
            write_enable();
            check(write_latch_en === 1'b0, "enable taken busy");
        end
        // Poll the status byte rather than wait the full time
        for (int i = 0; i < 400 && first_status_reg[SR_BUSY_BIT]; i++)
            @(negedge clk);
        if (first_status_reg[SR_BUSY_BIT] !== 1'b0)
        begin
            n_errors++;
            wrap_up();
        end
        if (seen)
            check(($time - t0) / 8 >= ERASE_CYCLES - 2 &&
                  ($time - t0) / 8 <= ERASE_CYCLES + 2, "busy span");
        block_protected = 1'b0;
        $display("erase %h bits %0d done", op, n);
    endtask

    // ------------------------------------------------------------
    // Quad read: address, mode, dummies, then two data nibbles
    // ------------------------------------------------------------
    task automatic read_case(input logic [7:0] op, input logic cmd,
                             input logic [2:0] dsel, input logic [7:0] mode);
        logic [23:0] a;
        logic [ADDR_BITS-1:0] ea;
        logic [7:0] d;
        int nd;
        a = 24'(rnd());
        dword_align_sel = seed[1];
        wrap_mode = seed[2];
        dummy_cycle_sel = dsel;
        nd = 2 * dsel + 2;
        ea = ADDR_BITS'((op == OP_READ_QUAD_ALIGNED || dword_align_sel)
             ? (a & ~MASK_DWORD) : a);
        d = mem_byte(ea);
        host.open_frame();
        if (cmd)
            host.send_bits({op, 32'h0}, 8);
        for (int i = 5; i >= 0; i--)
            host.pulse(a[i*4 +: 4]);
        // Mode nibbles count as the first two dummies
        host.pulse(mode[7:4]);
        for (int i = 2; i < nd; i++)
            host.pulse((i == 2) ? mode[3:0] : 4'(rnd()));
        host.half();
        check(io_oe === 4'h0, "lines driven early");
        host.pulse((nd == 2) ? mode[3:0] : 4'(rnd()));
        host.half();
        check(io_oe === 4'hf, "lines not driven");
        check(read_addr === ea, "read address");
        check(io_out === d[7:4], "high nibble");
        host.pulse(~io_in);
        host.half();
        check(io_out === d[3:0], "low nibble");
        host.close_frame();
        repeat (8) @(negedge clk);
        check(continuous_read === (mode[5:4] == MODE_CONT_PATTERN),
              "continuous flag");
        $display("read %h dummy sel %0d done", op, dsel);
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial
    begin
        repeat (12) @(negedge clk);
        reset = 1'b0;
        repeat (4) @(negedge clk);
        check(first_status_reg === 8'h00, "status after reset");
        erase_case(OP_ERASE_4K, 1'b1, 32, 1'b0);
        erase_case(OP_ERASE_32K, 1'b1, 32, 1'b0);
        erase_case(OP_ERASE_64K, 1'b1, 32, 1'b0);
        erase_case(OP_ERASE_64K, 1'b0, 32, 1'b0);
        erase_case(OP_ERASE_4K, 1'b1, 35, 1'b0);
        erase_case(OP_ERASE_32K, 1'b1, 24, 1'b0);
        erase_case(OP_ERASE_4K, 1'b1, 32, 1'b1);
        for (int s = 0; s < 5; s++)
        begin
            read_case(OP_READ_QUAD, 1'b1, 3'(s), 8'h00);
            read_case(OP_READ_QUAD_ALIGNED, 1'b1, 3'(s), 8'h00);
        end
        read_case(OP_READ_QUAD, 1'b1, 3'h1, 8'ha5);
        read_case(OP_READ_QUAD, 1'b0, 3'h2, 8'h00);
        wrap_up();
    end
endmodule // test_flash_quad_dummy_and_block_erase
